// *** rtl/pbs_pkg.sv ***
// Constants, types and cycle counts for the protection blanking and burst select block.
// Assumes a single 250 MHz system clock; every time here is turned into cycles of it.
`default_nettype none
package pbs_pkg;

    // System clock rate in kHz.
    localparam int CLK_KHZ = 250000;

    // Leading-edge blanking times in ns, rounded up to whole cycles.
    localparam int LEB_NORMAL_NS = 220;
    localparam int LEB_BURST_NS = 180;
    localparam int LEB_NORMAL_CYC = (LEB_NORMAL_NS * CLK_KHZ + 999999) / 1000000;
    localparam int LEB_BURST_CYC = (LEB_BURST_NS * CLK_KHZ + 999999) / 1000000;

    // Built-in blanking, spike filter and detection window.
    localparam int BLANK_MS = 20;
    localparam int BLANK_CYC = BLANK_MS * CLK_KHZ;
    localparam int SPIKE_US = 30;
    localparam int SPIKE_CYC = (SPIKE_US * CLK_KHZ) / 1000;
    localparam int DETECT_MS = 1;
    localparam int DETECT_CYC = DETECT_MS * CLK_KHZ;

    // Timer width, timer slots and the extended blanking count.
    localparam int TMR_W = 24;
    localparam int TMR_NUM = 4;
    localparam int TMR_LEB = 0;
    localparam int TMR_BLANK = 1;
    localparam int TMR_SPIKE = 2;
    localparam int TMR_WIN = 3;
    localparam int EXT_W = 9;
    localparam int EXT_COUNT = 256;
    localparam int DET_W = 16;

    // Default count boundaries of the level detection.
    localparam int DET_LVL0_MAX = 4;
    localparam int DET_LVL1_MAX = 40;
    localparam int DET_LVL2_MAX = 200;

    // Selected burst pair: entry threshold with its burst current limit.
    typedef enum logic [1:0] {
        PBS_LVL_160_045,
        PBS_LVL_142_037,
        PBS_LVL_127_031,
        PBS_LVL_NEVER
    } pbs_level_t;

    typedef enum logic [1:0] {EXT_IDLE, EXT_CHARGE, EXT_DISCH, EXT_DONE} pbs_ext_st_t;
    typedef enum logic [1:0] {DET_WAIT, DET_CHARGE, DET_DISCH, DET_DONE} pbs_det_st_t;

endpackage
`default_nettype wire

// *** rtl/pbs_tmr_if.sv ***
// Control and status of one cycle timer.
// Assumes the owner drives run and limit, the timer answers with expired.
`timescale 1ns/1ps
`default_nettype none
interface pbs_tmr_if;
    logic run;
    logic [pbs_pkg::TMR_W-1:0] limit;
    logic expired;
    modport ctrl (output run, output limit, input expired);
    modport tmr (input run, input limit, output expired);
endinterface
`default_nettype wire

// *** rtl/pbs_timer.sv ***
// Saturating cycle timer: counts while run is high, cleared while it is low.
// Assumes run and limit are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pbs_timer (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Timer control.
    pbs_tmr_if.tmr tmr
);

    logic [pbs_pkg::TMR_W-1:0] count;
    logic [pbs_pkg::TMR_W-1:0] next_count;

    always_comb begin
        if (!tmr.run) begin
            next_count = '0;
        end else if (count == tmr.limit) begin
            next_count = count;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Expired after limit cycles of uninterrupted run.
    assign tmr.expired = tmr.run && (count == tmr.limit);

endmodule // pbs_timer
`default_nettype wire

// *** rtl/pbs_blank_ctrl.sv ***
// Control-unit timing: sense blanking, built-in and extended blanking, spike filter, burst select.
// Assumes comparator and supply inputs are synchronous levels; i_reset_n is power-on only.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////////////////////////
module pbs_blank_ctrl #(
    parameter int BLANK_CYC = pbs_pkg::BLANK_CYC,
    parameter int SPIKE_CYC = pbs_pkg::SPIKE_CYC,
    parameter int DETECT_CYC = pbs_pkg::DETECT_CYC,
    parameter int EXT_COUNT = pbs_pkg::EXT_COUNT,
    parameter int DET_LVL0_MAX = pbs_pkg::DET_LVL0_MAX,
    parameter int DET_LVL1_MAX = pbs_pkg::DET_LVL1_MAX,
    parameter int DET_LVL2_MAX = pbs_pkg::DET_LVL2_MAX
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Supply and protection state.
    input wire logic i_supply_ok,
    input wire logic i_protection_active,
    // Current sensing.
    input wire logic i_gate_on,
    input wire logic i_burst_mode,
    input wire logic i_cs_cmp,
    output logic o_cs_trip,
    // Feedback comparators.
    input wire logic i_fb_below_burst,
    input wire logic i_overload_cmp,
    input wire logic i_fb_high_cmp,
    input wire logic i_fb_low_cmp,
    // Blanking capacitor comparators.
    input wire logic i_blank_pin_high_cmp,
    input wire logic i_blank_pin_low_cmp,
    // Switches.
    output logic o_blank_charge_switch,
    output logic o_blank_discharge_switch,
    output logic o_feedback_discharge_switch,
    // Mode results.
    output logic o_burst_enter,
    output logic o_ext_done,
    output logic o_auto_restart,
    output logic [1:0] o_burst_level,
    output logic o_level_valid
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Timers.

    pbs_tmr_if tmr [pbs_pkg::TMR_NUM] ();

    genvar g;
    generate
        for (g = 0; g < pbs_pkg::TMR_NUM; g++) begin : gen_tmr
            pbs_timer u_timer (
                .i_sys_clk(i_sys_clk),
                .i_reset_n(i_reset_n),
                .tmr(tmr[g])
            );
        end
    endgenerate

    logic leb_active;
    logic next_leb_active;
    logic gate_q;
    logic cs_trip;
    logic next_cs_trip;
    logic burst_enter;
    logic next_burst_enter;
    logic auto_restart;
    logic next_auto_restart;
    logic blank_exp;
    logic spike_exp;
    logic win_exp;
    logic burst_allowed;
    logic overload_gate;
    pbs_pkg::pbs_ext_st_t ext_st;
    pbs_pkg::pbs_ext_st_t next_ext_st;
    logic [pbs_pkg::EXT_W-1:0] ext_cnt;
    logic [pbs_pkg::EXT_W-1:0] next_ext_cnt;
    pbs_pkg::pbs_det_st_t det_st;
    pbs_pkg::pbs_det_st_t next_det_st;
    logic [pbs_pkg::DET_W-1:0] det_cnt;
    logic [pbs_pkg::DET_W-1:0] next_det_cnt;
    pbs_pkg::pbs_level_t level;
    pbs_pkg::pbs_level_t next_level;

    assign tmr[pbs_pkg::TMR_LEB].run = leb_active;
    assign tmr[pbs_pkg::TMR_LEB].limit = i_burst_mode ?
        pbs_pkg::TMR_W'(pbs_pkg::LEB_BURST_CYC) : pbs_pkg::TMR_W'(pbs_pkg::LEB_NORMAL_CYC);
    // Shared by burst entry and overload restart; held at zero otherwise.
    assign tmr[pbs_pkg::TMR_BLANK].run = i_supply_ok &&
        ((i_fb_below_burst && burst_allowed) || i_overload_cmp);
    assign tmr[pbs_pkg::TMR_BLANK].limit = pbs_pkg::TMR_W'(BLANK_CYC);
    assign tmr[pbs_pkg::TMR_SPIKE].run = overload_gate && !auto_restart;
    assign tmr[pbs_pkg::TMR_SPIKE].limit = pbs_pkg::TMR_W'(SPIKE_CYC);
    assign tmr[pbs_pkg::TMR_WIN].run = (det_st == pbs_pkg::DET_CHARGE) ||
        (det_st == pbs_pkg::DET_DISCH);
    assign tmr[pbs_pkg::TMR_WIN].limit = pbs_pkg::TMR_W'(DETECT_CYC);

    assign blank_exp = tmr[pbs_pkg::TMR_BLANK].expired;
    assign spike_exp = tmr[pbs_pkg::TMR_SPIKE].expired;
    assign win_exp = tmr[pbs_pkg::TMR_WIN].expired;
    assign burst_allowed = (level != pbs_pkg::PBS_LVL_NEVER);
    assign overload_gate = i_overload_cmp && blank_exp && (ext_st == pbs_pkg::EXT_DONE);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sense blanking, burst entry and auto-restart.

    always_comb begin
        next_leb_active = leb_active;
        if (i_gate_on && !gate_q) begin
            next_leb_active = 1'b1;
        end else if (tmr[pbs_pkg::TMR_LEB].expired || !i_gate_on) begin
            next_leb_active = 1'b0;
        end
        next_cs_trip = i_cs_cmp && i_gate_on && !next_leb_active && !leb_active;
        next_burst_enter = blank_exp && i_fb_below_burst && burst_allowed;
        next_auto_restart = i_supply_ok && (auto_restart || spike_exp);
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            leb_active <= 1'b0;
            gate_q <= 1'b0;
            cs_trip <= 1'b0;
            burst_enter <= 1'b0;
            auto_restart <= 1'b0;
        end else begin
            leb_active <= next_leb_active;
            gate_q <= i_gate_on;
            cs_trip <= next_cs_trip;
            burst_enter <= next_burst_enter;
            auto_restart <= next_auto_restart;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Extended blanking counter.

    always_comb begin
        next_ext_st = ext_st;
        next_ext_cnt = ext_cnt;
        if (!(i_supply_ok && i_overload_cmp)) begin
            next_ext_st = pbs_pkg::EXT_IDLE;
            next_ext_cnt = '0;
        end else begin
            unique case (ext_st)
                pbs_pkg::EXT_IDLE: begin
                    if (blank_exp) begin
                        next_ext_st = pbs_pkg::EXT_CHARGE;
                    end
                end
                pbs_pkg::EXT_CHARGE: begin
                    if (i_blank_pin_high_cmp) begin
                        next_ext_cnt = ext_cnt + 1'b1;
                        if (ext_cnt == pbs_pkg::EXT_W'(EXT_COUNT - 1)) begin
                            next_ext_st = pbs_pkg::EXT_DONE;
                        end else begin
                            next_ext_st = pbs_pkg::EXT_DISCH;
                        end
                    end
                end
                pbs_pkg::EXT_DISCH: begin
                    if (i_blank_pin_low_cmp) begin
                        next_ext_st = pbs_pkg::EXT_CHARGE;
                    end
                end
                pbs_pkg::EXT_DONE: begin
                    next_ext_st = pbs_pkg::EXT_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ext_st <= pbs_pkg::EXT_IDLE;
            ext_cnt <= '0;
        end else begin
            ext_st <= next_ext_st;
            ext_cnt <= next_ext_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Burst level detection, run once after power-on.

    always_comb begin
        next_det_st = det_st;
        next_det_cnt = det_cnt;
        next_level = level;
        unique case (det_st)
            pbs_pkg::DET_WAIT: begin
                if (i_supply_ok && !i_protection_active) begin
                    next_det_st = pbs_pkg::DET_CHARGE;
                end
            end
            pbs_pkg::DET_CHARGE, pbs_pkg::DET_DISCH: begin
                if (!i_supply_ok) begin
                    next_det_st = pbs_pkg::DET_WAIT;
                    next_det_cnt = '0;
                end else if (win_exp) begin
                    next_det_st = pbs_pkg::DET_DONE;
                    if (det_cnt <= pbs_pkg::DET_W'(DET_LVL0_MAX)) begin
                        next_level = pbs_pkg::PBS_LVL_160_045;
                    end else if (det_cnt <= pbs_pkg::DET_W'(DET_LVL1_MAX)) begin
                        next_level = pbs_pkg::PBS_LVL_142_037;
                    end else if (det_cnt <= pbs_pkg::DET_W'(DET_LVL2_MAX)) begin
                        next_level = pbs_pkg::PBS_LVL_127_031;
                    end else begin
                        next_level = pbs_pkg::PBS_LVL_NEVER;
                    end
                end else if (det_st == pbs_pkg::DET_CHARGE && i_fb_high_cmp) begin
                    next_det_st = pbs_pkg::DET_DISCH;
                    if (det_cnt != '1) begin
                        next_det_cnt = det_cnt + 1'b1;
                    end
                end else if (det_st == pbs_pkg::DET_DISCH && i_fb_low_cmp) begin
                    next_det_st = pbs_pkg::DET_CHARGE;
                end
            end
            pbs_pkg::DET_DONE: begin
                next_det_st = pbs_pkg::DET_DONE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            det_st <= pbs_pkg::DET_WAIT;
            det_cnt <= '0;
            level <= pbs_pkg::PBS_LVL_NEVER;
        end else begin
            det_st <= next_det_st;
            det_cnt <= next_det_cnt;
            level <= next_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_cs_trip = cs_trip;
    assign o_burst_enter = burst_enter;
    assign o_auto_restart = auto_restart;
    assign o_blank_charge_switch = (ext_st == pbs_pkg::EXT_CHARGE);
    assign o_blank_discharge_switch = (ext_st == pbs_pkg::EXT_DISCH);
    assign o_ext_done = (ext_st == pbs_pkg::EXT_DONE);
    assign o_feedback_discharge_switch = (det_st == pbs_pkg::DET_DISCH);
    assign o_burst_level = level;
    assign o_level_valid = (det_st == pbs_pkg::DET_DONE);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    leb_mask_a: assert property ($rose(i_gate_on) |-> (!o_cs_trip) [*8])
        else $error("Current-sense trip seen inside the blanking window.");
    ext_start_a: assert property ((ext_st == pbs_pkg::EXT_IDLE && i_supply_ok &&
        i_overload_cmp && blank_exp) |=> o_blank_charge_switch && !o_blank_discharge_switch)
        else $error("Charge switch not closed when extended blanking starts.");
    ext_count_a: assert property ((ext_st == pbs_pkg::EXT_CHARGE && i_supply_ok &&
        i_overload_cmp && i_blank_pin_high_cmp) |=> ext_cnt == $past(ext_cnt) + 1'b1 &&
        !o_blank_charge_switch)
        else $error("Extended count did not step on the high comparator.");
    ext_recharge_a: assert property ((ext_st == pbs_pkg::EXT_DISCH && i_supply_ok &&
        i_overload_cmp && i_blank_pin_low_cmp) |=> o_blank_charge_switch &&
        !o_blank_discharge_switch)
        else $error("Charge phase not resumed on the low comparator.");
    ext_stop_a: assert property (o_ext_done |-> ext_cnt == pbs_pkg::EXT_W'(EXT_COUNT))
        else $error("Extended counter done at a count other than its end value.");
    gate_block_a: assert property ($rose(o_auto_restart) |-> $past(overload_gate))
        else $error("Auto-restart raised without the overload gate open.");
    spike_wait_a: assert property ($rose(overload_gate) |=> (!o_auto_restart) [*8])
        else $error("Auto-restart raised inside the spike filter.");
    burst_cause_a: assert property (o_burst_enter |-> $past(blank_exp && i_fb_below_burst))
        else $error("Burst entry without expired blanking and low feedback.");
    blank_hold_a: assert property ((!i_fb_below_burst && !i_overload_cmp) |-> !blank_exp)
        else $error("Blanking timer not held at zero in normal operation.");
    never_burst_a: assert property ((o_level_valid &&
        o_burst_level == pbs_pkg::PBS_LVL_NEVER) |-> !o_burst_enter)
        else $error("Burst entered with burst disabled.");
    det_postpone_a: assert property ((det_st == pbs_pkg::DET_WAIT &&
        i_protection_active) |=> det_st == pbs_pkg::DET_WAIT)
        else $error("Detection started while a protection was active.");
    det_once_a: assert property (o_level_valid |=> o_level_valid && $stable(o_burst_level))
        else $error("Burst level changed after detection.");
    det_step_a: assert property ((det_st == pbs_pkg::DET_CHARGE && i_supply_ok &&
        i_fb_high_cmp && !win_exp) |=> o_feedback_discharge_switch)
        else $error("Feedback discharge switch not closed at the high level.");

    restart_c: cover property (o_ext_done ##[1:10] $rose(o_auto_restart));
    burst_c: cover property ($rose(o_burst_enter));
    level_c: cover property ($rose(o_level_valid) && o_burst_level == pbs_pkg::PBS_LVL_142_037);

endmodule // pbs_blank_ctrl
`default_nettype wire

// *** verification/pbs_analog_model.sv ***
// Behavioural model of the analog side: blanking pin and feedback pin comparators.
// Assumes the block drives its switches from registers on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pbs_analog_model (
    // Clock.
    input wire logic i_sys_clk,
    // Switches driven by the block.
    input wire logic i_blank_charge_switch,
    input wire logic i_blank_discharge_switch,
    input wire logic i_feedback_discharge_switch,
    // Feedback ramp length in cycles; a longer ramp stands for a larger capacitor.
    input wire logic [15:0] i_fb_ramp,
    // Comparator outputs.
    output logic o_blank_pin_high_cmp,
    output logic o_blank_pin_low_cmp,
    output logic o_fb_high_cmp,
    output logic o_fb_low_cmp
);
    localparam logic [15:0] BLANK_RAMP = 16'h0002;
    logic [15:0] bk_v = 16'h0000;
    logic [15:0] fb_v = 16'h0000;

    // The blanking pin only moves while a switch is closed; the feedback pin recharges itself.
    always @(posedge i_sys_clk) begin
        if (i_blank_charge_switch && bk_v < BLANK_RAMP) begin
            bk_v <= bk_v + 16'h0001;
        end else if (i_blank_discharge_switch && bk_v != 16'h0000) begin
            bk_v <= bk_v - 16'h0001;
        end
        if (!i_feedback_discharge_switch && fb_v < i_fb_ramp) begin
            fb_v <= fb_v + 16'h0001;
        end else if (i_feedback_discharge_switch && fb_v != 16'h0000) begin
            fb_v <= fb_v - 16'h0001;
        end
    end

    assign o_blank_pin_high_cmp = (bk_v >= BLANK_RAMP);
    assign o_blank_pin_low_cmp = (bk_v == 16'h0000);
    assign o_fb_high_cmp = (fb_v >= i_fb_ramp);
    assign o_fb_low_cmp = (fb_v == 16'h0000);
endmodule // pbs_analog_model
`default_nettype wire

// *** verification/pbs_blank_ctrl_bench.sv ***
// Self-checking bench for the protection blanking and burst select block.
// Assumes the analog model answers the switches; long times are shortened by parameters.
`timescale 1ns/1ps
`default_nettype none
module pbs_blank_ctrl_bench;
    localparam int BLK = 50;
    localparam int SPK = 10;
    localparam int DET = 1200;
    localparam int EXT = 4;
    logic clk, rst_n, supply_ok, prot, gate_on, burst_mode, cs_cmp, fb_below, ovl;
    logic cs_trip, bk_chg, bk_dis, fb_dis, burst_enter, ext_done, auto_rst, lvl_valid;
    logic bk_hi, bk_lo, fb_hi, fb_lo;
    logic [1:0] lvl;
    logic [15:0] ramp;
    int n_fail, cmp_count;

    pbs_blank_ctrl #(.BLANK_CYC(BLK), .SPIKE_CYC(SPK), .DETECT_CYC(DET), .EXT_COUNT(EXT))
    pbs_blank_ctrl_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_supply_ok(supply_ok),
        .i_protection_active(prot), .i_gate_on(gate_on), .i_burst_mode(burst_mode),
        .i_cs_cmp(cs_cmp), .o_cs_trip(cs_trip), .i_fb_below_burst(fb_below),
        .i_overload_cmp(ovl), .i_fb_high_cmp(fb_hi), .i_fb_low_cmp(fb_lo),
        .i_blank_pin_high_cmp(bk_hi), .i_blank_pin_low_cmp(bk_lo),
        .o_blank_charge_switch(bk_chg), .o_blank_discharge_switch(bk_dis),
        .o_feedback_discharge_switch(fb_dis), .o_burst_enter(burst_enter),
        .o_ext_done(ext_done), .o_auto_restart(auto_rst), .o_burst_level(lvl),
        .o_level_valid(lvl_valid));

    pbs_analog_model pbs_analog_model_i (.i_sys_clk(clk), .i_blank_charge_switch(bk_chg),
        .i_blank_discharge_switch(bk_dis), .i_feedback_discharge_switch(fb_dis),
        .i_fb_ramp(ramp), .o_blank_pin_high_cmp(bk_hi), .o_blank_pin_low_cmp(bk_lo),
        .o_fb_high_cmp(fb_hi), .o_fb_low_cmp(fb_lo));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic power_up(input logic [15:0] r, input logic p);
        rst_n = 1'b0;
        supply_ok = 1'b0;
        prot = p;
        ramp = r;
        step(10);
        rst_n = 1'b1;
        step(1);
        supply_ok = 1'b1;
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Each ramp length selects one level; the protected start comes second.
    task automatic test_levels();
        logic [15:0] ramps [4] = '{16'h0001, 16'h00c8, 16'h0003, 16'h0014};
        logic [1:0] exp [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
        for (int i = 0; i < 4; i++) begin
            power_up(ramps[i], i == 1);
            if (i == 1) begin
                step(300);
                chk("held valid", 8'h00, {7'h00, lvl_valid});
                chk("held switch", 8'h00, {7'h00, fb_dis});
                prot = 1'b0;
            end
            step(DET - 10);
            chk("early valid", 8'h00, {7'h00, lvl_valid});
            for (int k = 0; k < 60 && lvl_valid !== 1'b1; k++) step(1);
            chk("level valid", 8'h01, {7'h00, lvl_valid});
            chk("burst level", {6'h00, exp[i]}, {6'h00, lvl});
            step(20);
            chk("stopped switch", 8'h00, {7'h00, fb_dis});
            if (i == 0) begin
                fb_below = 1'b1;
                step(BLK + 10);
                chk("never burst", 8'h00, {7'h00, burst_enter});
                fb_below = 1'b0;
            end
        end
        supply_ok = 1'b0;
        step(5);
        supply_ok = 1'b1;
        ramp = 16'h0001;
        step(DET + 50);
        chk("restart switch", 8'h00, {7'h00, fb_dis});
        chk("restart level", 8'h01, {6'h00, lvl});
        $display("test_levels done");
    endtask

    task automatic test_leb(input logic bm, input int len);
        burst_mode = bm;
        cs_cmp = 1'b1;
        gate_on = 1'b1;
        step(len + 1);
        chk("blanked trip", 8'h00, {7'h00, cs_trip});
        for (int k = 0; k < 6 && cs_trip !== 1'b1; k++) step(1);
        chk("trip after blank", 8'h01, {7'h00, cs_trip});
        gate_on = 1'b0;
        step(3);
        chk("trip gate off", 8'h00, {7'h00, cs_trip});
        cs_cmp = 1'b0;
        step(1);
        $display("test_leb done");
    endtask

    task automatic test_burst();
        fb_below = 1'b1;
        step(BLK - 5);
        fb_below = 1'b0;
        step(10);
        chk("short dip", 8'h00, {7'h00, burst_enter});
        fb_below = 1'b1;
        step(BLK - 3);
        chk("early burst", 8'h00, {7'h00, burst_enter});
        for (int k = 0; k < 8 && burst_enter !== 1'b1; k++) step(1);
        chk("burst enter", 8'h01, {7'h00, burst_enter});
        fb_below = 1'b0;
        step(3);
        chk("burst left", 8'h00, {7'h00, burst_enter});
        $display("test_burst done");
    endtask

    task automatic test_overload();
        logic prev;
        logic [7:0] rises;
        rises = 8'h00;
        ovl = 1'b1;
        step(BLK - 3);
        chk("early charge", 8'h00, {7'h00, bk_chg});
        for (int k = 0; k < 400 && ext_done !== 1'b1; k++) begin
            prev = bk_chg;
            step(1);
            if (bk_chg === 1'b1 && prev === 1'b0) begin
                rises++;
            end
        end
        chk("ext done", 8'h01, {7'h00, ext_done});
        chk("charge phases", EXT[7:0], rises);
        chk("switches off", 8'h00, {6'h00, bk_chg, bk_dis});
        chk("gate closed", 8'h00, {7'h00, auto_rst});
        step(SPK - 3);
        chk("spike blank", 8'h00, {7'h00, auto_rst});
        for (int k = 0; k < 8 && auto_rst !== 1'b1; k++) step(1);
        chk("auto restart", 8'h01, {7'h00, auto_rst});
        ovl = 1'b0;
        supply_ok = 1'b0;
        step(2);
        chk("lockout clear", 8'h00, {6'h00, auto_rst, ext_done});
        supply_ok = 1'b1;
        $display("test_overload done");
    endtask

    initial begin
        n_fail = 0;
        cmp_count = 0;
        gate_on = 1'b0;
        burst_mode = 1'b0;
        cs_cmp = 1'b0;
        fb_below = 1'b0;
        ovl = 1'b0;
        test_levels();
        test_leb(1'b0, pbs_pkg::LEB_NORMAL_CYC);
        test_leb(1'b1, pbs_pkg::LEB_BURST_CYC);
        test_burst();
        test_overload();
        print_verdict();
    end
endmodule // pbs_blank_ctrl_bench
`default_nettype wire
